// ==== shared/wait_gen_consts.svh ====
// Offsets, field positions, reset values and cycle tables of the wait-state generator.
// Assumes inclusion by bare name from the design files.
`ifndef WAIT_GEN_CONSTS_SVH
`define WAIT_GEN_CONSTS_SVH

`define WAIT_W              4
`define ADDR_DEC_W          8
`define CFG_ADDR            8'h00
`define WAITS_ADDR          8'h04
`define STATUS_ADDR         8'h08

`define CFG_EMUL_EN_BIT     0
`define CFG_FAST_BIT        1
`define CFG_TWO_CLK_BIT     2
`define CFG_LOCK_I_BIT      3
`define CFG_LOCK_D_BIT      4
`define CFG_PRIO_A_D_BIT    5
`define CFG_PRIO_B_D_BIT    6
`define CFG_RESET           7'h00

`define WAITS_BURST_LSB     0
`define WAITS_SIMPLE_LSB    8
`define BURST_MIN_RESET     4'h1
`define SIMPLE_MIN_RESET    4'h2
`define BURST_MIN_LO        4'h1
`define BURST_MIN_HI        4'h4
`define SIMPLE_MIN_LO       4'h2
`define SIMPLE_MIN_HI       4'h9

`define STATUS_BUSY_I_BIT   0
`define STATUS_BUSY_D_BIT   1
`define STATUS_LAST_I_LSB   8
`define STATUS_LAST_D_LSB   12

// Total cycles per access: emulation initial, burst, burst resume per mode; then target fast initial, plain, collision extra
`define CYC_N1_INIT         4'h3
`define CYC_N1_BURST        4'h2
`define CYC_N1_RESUME       4'h3
`define CYC_N2_INIT         4'h4
`define CYC_N2_BURST        4'h3
`define CYC_N2_RESUME       4'h4
`define CYC_F2_INIT         4'h5
`define CYC_F2_BURST        4'h3
`define CYC_F2_RESUME       4'h4
`define CYC_TGT_FAST_INIT   4'h2
`define CYC_PLAIN           4'h1
`define COLLIDE_EXTRA       4'h1

`endif

// ==== shared/wait_gen_pkg.sv ====
// Types shared by the wait-state generator modules.
// Assumes the constants header is on the include path.
`default_nettype none
package wait_gen_pkg;
    typedef enum logic [1:0] {
        ACC_INITIAL,
        ACC_BURST,
        ACC_RESUME
    } access_kind_type;

    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } wait_state_type;
endpackage
`default_nettype wire

// ==== verilog/bus_wait_counter.sv ====
// One bus's wait-state timer: loads a wait count, then releases ready.
// Assumes start only while idle and a target ready synchronous to clk_in.
`default_nettype none
module bus_wait_counter
    import wait_gen_pkg::*;
#(
    parameter int CNT_W = 4
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             start_in,
    input  wire logic [CNT_W-1:0] waits_in,
    input  wire logic             need_target_in,
    input  wire logic             target_rdy_in,
    output logic                  busy_out,
    output logic [CNT_W-1:0]      count_out,
    output logic                  rdy_out
);
    wait_state_type   state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             need_ff;
    logic             seen_ff;

    // Narrower counters cannot hold the largest simple minimum
    if (CNT_W < 4) begin : g_width_check
        $error("bus_wait_counter: CNT_W must be at least 4");
    end

    // Target ready may come before the own minimum ends; remember it
    assign rdy_out   = (state_ff == ST_WAIT) && (cnt_ff == '0)
                       && (!need_ff || seen_ff || target_rdy_in);
    assign busy_out  = (state_ff == ST_WAIT);
    assign count_out = cnt_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_in) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (rdy_out) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_ff  <= '0;
            need_ff <= 1'b0;
        end else if (start_in && (state_ff == ST_IDLE)) begin
            cnt_ff  <= waits_in;
            need_ff <= need_target_in;
        end else if ((state_ff == ST_WAIT) && (cnt_ff != '0)) begin
            cnt_ff  <= cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seen_ff <= 1'b0;
        end else if (start_in && (state_ff == ST_IDLE)) begin
            seen_ff <= 1'b0;
        end else if ((state_ff == ST_WAIT) && target_rdy_in) begin
            seen_ff <= 1'b1;
        end
    end
endmodule // bus_wait_counter
`default_nettype wire

// ==== verilog/emul_wait_gen.sv ====
// Wait-state generator for overlay memory and target accesses, AHB-Lite configured.
// Assumes bus requests and target ready are synchronous to clk_in, the system clock.
//
// Operation
// - Memory access length is one or two system clocks, chosen by config.
// - Programmable burst minimum wait count, legal values one to four.
// - Programmable simple minimum wait count, legal values two to nine.
// - Bank collision between buses costs the non-priority bus one extra clock.
// - Inherent waits are total cycles minus one, compared with programmed minimum.
// - Too few inherent waits get extra waits up to the programmed minimum.
// - Fast two-clock first access takes five cycles (four waits) without collision.
// - Initial/burst minimum waits: 2/1, 3/2, 4/2 per speed setting.
// - Burst resume costs 2 waits normal one-clock, 3 in two-clock modes.
// - Target gets no minimum waits except one on fast initial access.
// - Emulation burst and synchronous accesses always get at least one wait.
// - Target ready comes after larger of table minimum and target waits.
// - Emulation waits are max of table, programmed, and locked target waits.
// - Fast mode with mapper adds one translation wait to initial accesses only.
// - Emulation memory off: no own waits, all accesses go to target.
// - With ready locking, emulation ready waits for target ready too.
`default_nettype none
`include "wait_gen_consts.svh"
module emul_wait_gen
    import wait_gen_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    input  wire logic        i_bus_request_strobe_in,
    input  wire logic        i_burst_in,
    input  wire logic        i_resume_in,
    input  wire logic        i_emul_hit_in,
    input  wire logic        i_bank_in,
    output logic             i_rdy_out,
    output logic             i_to_emul_out,
    input  wire logic        d_bus_request_strobe_in,
    input  wire logic        d_burst_in,
    input  wire logic        d_resume_in,
    input  wire logic        d_emul_hit_in,
    input  wire logic        d_bank_in,
    output logic             d_rdy_out,
    output logic             d_to_emul_out,
    input  wire logic        target_rdy_in
);
    logic [6:0]          cfg_ff;
    logic [`WAIT_W-1:0]  burst_min_ff;
    logic [`WAIT_W-1:0]  simple_min_ff;
    logic [`WAIT_W-1:0]  last_i_ff;
    logic [`WAIT_W-1:0]  last_d_ff;
    logic [31:0]         hrdata_ff;
    logic                wr_pend_ff;
    logic [`ADDR_DEC_W-1:0] wr_addr_ff;
    logic                i_to_emul_ff;
    logic                d_to_emul_ff;

    logic emul_en;
    logic fast;
    logic two_clk;
    logic i_busy;
    logic d_busy;
    logic i_take;
    logic d_take;
    logic same_bank;
    logic data_prio;
    logic i_collide;
    logic d_collide;
    logic i_need_tgt;
    logic d_need_tgt;
    logic [`WAIT_W-1:0] i_waits;
    logic [`WAIT_W-1:0] d_waits;
    logic [`WAIT_W-1:0] i_count;
    logic [`WAIT_W-1:0] d_count;
    logic [`WAIT_W-1:0] wr_burst;
    logic [`WAIT_W-1:0] wr_simple;
    logic               addr_phase;
    access_kind_type    i_kind;
    access_kind_type    d_kind;

    assign emul_en = cfg_ff[`CFG_EMUL_EN_BIT];
    assign fast    = cfg_ff[`CFG_FAST_BIT];
    assign two_clk = cfg_ff[`CFG_TWO_CLK_BIT];

    function automatic access_kind_type kind_of(input logic burst, input logic resume);
        if (resume) begin
            return ACC_RESUME;
        end
        return burst ? ACC_BURST : ACC_INITIAL;
    endfunction

    // Fast mode forces the two-clock column; fast with one-clock memory is not a legal setup
    function automatic logic [`WAIT_W-1:0] calc_waits(input logic en, input logic fst,
                                                      input logic two, input logic hit,
                                                      input logic collide,
                                                      input access_kind_type kind,
                                                      input logic [`WAIT_W-1:0] bmin,
                                                      input logic [`WAIT_W-1:0] smin);
        logic [`WAIT_W-1:0] cyc;
        logic [`WAIT_W-1:0] prog;
        logic [`WAIT_W-1:0] inh;
        cyc  = `CYC_PLAIN;
        prog = '0;
        if (!en) begin
            cyc = `CYC_PLAIN;
        end else if (!hit) begin
            if (fst && (kind == ACC_INITIAL)) begin
                cyc = `CYC_TGT_FAST_INIT;
            end
        end else begin
            case (kind)
                ACC_INITIAL: cyc = fst ? `CYC_F2_INIT : (two ? `CYC_N2_INIT : `CYC_N1_INIT);
                ACC_BURST:   cyc = fst ? `CYC_F2_BURST : (two ? `CYC_N2_BURST : `CYC_N1_BURST);
                ACC_RESUME:  cyc = fst ? `CYC_F2_RESUME : (two ? `CYC_N2_RESUME : `CYC_N1_RESUME);
                default:     cyc = `CYC_PLAIN;
            endcase
            if (collide) begin
                cyc = cyc + `COLLIDE_EXTRA;
            end
            prog = (kind == ACC_INITIAL) ? smin : bmin;
        end
        inh = cyc - 1'b1;
        return (inh > prog) ? inh : prog;
    endfunction

    assign i_take    = i_bus_request_strobe_in && !i_busy;
    assign d_take    = d_bus_request_strobe_in && !d_busy;
    assign i_kind    = kind_of(i_burst_in, i_resume_in);
    assign d_kind    = kind_of(d_burst_in, d_resume_in);
    assign same_bank = (i_bank_in == d_bank_in);
    assign data_prio = i_bank_in ? cfg_ff[`CFG_PRIO_B_D_BIT] : cfg_ff[`CFG_PRIO_A_D_BIT];
    assign i_collide = i_take && d_take && emul_en && i_emul_hit_in && d_emul_hit_in
                       && same_bank && data_prio;
    assign d_collide = i_take && d_take && emul_en && i_emul_hit_in && d_emul_hit_in
                       && same_bank && !data_prio;
    assign i_waits   = calc_waits(emul_en, fast, two_clk, i_emul_hit_in, i_collide, i_kind,
                                  burst_min_ff, simple_min_ff);
    assign d_waits   = calc_waits(emul_en, fast, two_clk, d_emul_hit_in, d_collide, d_kind,
                                  burst_min_ff, simple_min_ff);
    // Target accesses always wait for target ready; emulation only when locked
    assign i_need_tgt = !(emul_en && i_emul_hit_in) || cfg_ff[`CFG_LOCK_I_BIT];
    assign d_need_tgt = !(emul_en && d_emul_hit_in) || cfg_ff[`CFG_LOCK_D_BIT];

    // Separate timers so both buses run concurrently
    bus_wait_counter #(.CNT_W(`WAIT_W)) u_i_cnt (
        .clk_in         (clk_in),
        .resetn_in      (resetn_in),
        .start_in       (i_take),
        .waits_in       (i_waits),
        .need_target_in (i_need_tgt),
        .target_rdy_in  (target_rdy_in),
        .busy_out       (i_busy),
        .count_out      (i_count),
        .rdy_out        (i_rdy_out)
    );

    bus_wait_counter #(.CNT_W(`WAIT_W)) u_d_cnt (
        .clk_in         (clk_in),
        .resetn_in      (resetn_in),
        .start_in       (d_take),
        .waits_in       (d_waits),
        .need_target_in (d_need_tgt),
        .target_rdy_in  (target_rdy_in),
        .busy_out       (d_busy),
        .count_out      (d_count),
        .rdy_out        (d_rdy_out)
    );

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            i_to_emul_ff <= 1'b0;
            d_to_emul_ff <= 1'b0;
            last_i_ff    <= '0;
            last_d_ff    <= '0;
        end else begin
            if (i_take) begin
                i_to_emul_ff <= emul_en && i_emul_hit_in;
                last_i_ff    <= i_waits;
            end
            if (d_take) begin
                d_to_emul_ff <= emul_en && d_emul_hit_in;
                last_d_ff    <= d_waits;
            end
        end
    end
    assign i_to_emul_out = i_to_emul_ff;
    assign d_to_emul_out = d_to_emul_ff;

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_phase    = hsel_in && htrans_in[1] && hready_in;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_ff;
    assign wr_burst      = hwdata_in[`WAITS_BURST_LSB +: `WAIT_W];
    assign wr_simple     = hwdata_in[`WAITS_SIMPLE_LSB +: `WAIT_W];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff  <= '0;
        end else begin
            wr_pend_ff <= addr_phase && hwrite_in;
            if (addr_phase) begin
                wr_addr_ff <= haddr_in[`ADDR_DEC_W-1:0];
            end
            if (addr_phase && !hwrite_in) begin
                case (haddr_in[`ADDR_DEC_W-1:0])
                    `CFG_ADDR:    hrdata_ff <= {25'h0000000, cfg_ff};
                    `WAITS_ADDR:  hrdata_ff <= {20'h00000, simple_min_ff, 4'h0, burst_min_ff};
                    `STATUS_ADDR: hrdata_ff <= {16'h0000, last_d_ff, last_i_ff, 6'h00,
                                                d_busy, i_busy};
                    default:      hrdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_ff <= `CFG_RESET;
        end else if (wr_pend_ff && (wr_addr_ff == `CFG_ADDR)) begin
            cfg_ff <= hwdata_in[6:0];
        end
    end

    // Out-of-range minimums are refused so the counters never see an illegal value
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            burst_min_ff  <= `BURST_MIN_RESET;
            simple_min_ff <= `SIMPLE_MIN_RESET;
        end else if (wr_pend_ff && (wr_addr_ff == `WAITS_ADDR)) begin
            if ((wr_burst >= `BURST_MIN_LO) && (wr_burst <= `BURST_MIN_HI)) begin
                burst_min_ff <= wr_burst;
            end
            if ((wr_simple >= `SIMPLE_MIN_LO) && (wr_simple <= `SIMPLE_MIN_HI)) begin
                simple_min_ff <= wr_simple;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_quiet4_then_rdy;
        (!i_rdy_out) [*4] ##1 i_rdy_out;
    endsequence

    sequence s_d_one_wait;
        !d_rdy_out ##1 d_rdy_out;
    endsequence

    property p_off_no_waits;
        i_take && !emul_en |-> (i_waits == 4'h0) ##1 !i_to_emul_out;
    endproperty
    a_off_no_waits: assert property (p_off_no_waits) else $error("waits with memory off");

    property p_fast_target_init;
        i_take && emul_en && fast && !i_emul_hit_in && !i_burst_in && !i_resume_in
            |-> (i_waits == 4'h1);
    endproperty
    a_fast_target_init: assert property (p_fast_target_init) else $error("fast target wait");

    // Table minimum of four waits governs the five-cycle fast first access
    property p_fast_first_access;
        i_take && emul_en && fast && i_emul_hit_in && !i_collide && (i_kind == ACC_INITIAL)
            && (simple_min_ff <= 4'h4) |-> (i_waits == 4'h4);
    endproperty
    a_fast_first_access: assert property (p_fast_first_access) else $error("fast first wait");

    property p_simple_min;
        i_take && emul_en && i_emul_hit_in && (i_kind == ACC_INITIAL)
            |-> (i_waits >= simple_min_ff) && (i_waits >= 4'h2);
    endproperty
    a_simple_min: assert property (p_simple_min) else $error("simple minimum missed");

    property p_burst_min;
        d_take && emul_en && d_emul_hit_in && (d_kind != ACC_INITIAL)
            |-> (d_waits >= burst_min_ff) && (d_waits >= 4'h1);
    endproperty
    a_burst_min: assert property (p_burst_min) else $error("burst minimum missed");

    property p_resume_normal1;
        i_take && emul_en && !fast && !two_clk && i_emul_hit_in && !i_collide
            && (i_kind == ACC_RESUME) && (burst_min_ff <= 4'h2) |-> (i_waits == 4'h2);
    endproperty
    a_resume_normal1: assert property (p_resume_normal1) else $error("resume wait wrong");

    property p_collide_loser;
        d_collide && !fast && !two_clk && (d_kind == ACC_INITIAL) |-> (d_waits >= 4'h3);
    endproperty
    a_collide_loser: assert property (p_collide_loser) else $error("no collision cycle");

    property p_timing_four;
        i_take && emul_en && i_emul_hit_in && !i_need_tgt && (i_waits == 4'h4)
            |-> ##1 s_quiet4_then_rdy;
    endproperty
    a_timing_four: assert property (p_timing_four) else $error("ready not after waits");

    property p_d_independent;
        d_take && i_busy && emul_en && d_emul_hit_in && !d_need_tgt && (d_waits == 4'h1)
            |-> ##1 s_d_one_wait;
    endproperty
    a_d_independent: assert property (p_d_independent) else $error("data bus stalled");

    property p_lock_hold;
        i_busy && (i_count == 4'h0) && i_need_tgt && !target_rdy_in && !i_rdy_out
            |=> !i_rdy_out || target_rdy_in || $past(target_rdy_in);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("ready before target");
endmodule // emul_wait_gen
`default_nettype wire

// ==== verification/target_sys_model.sv ====
// Target system model: answers each rise of the ORed request strobes with ready after a set wait count.
// Assumes the block's request strobes and its own ready are all on clk_in.
`default_nettype none
module target_sys_model (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       i_req_in,
    input  wire logic       d_req_in,
    input  wire logic [3:0] waits_in,
    output logic            target_rdy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       prev_ff;
    logic       busy_ff;
    logic [3:0] cnt_ff;
    wire logic  req = i_req_in | d_req_in;
    // Ready for one cycle only, so a late block cannot see a stale answer
    assign target_rdy_out = busy_ff && (cnt_ff == waits_in + 4'h1);
    // Rising strobe only: a strobe held past ready must not start a second answer
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_ff <= 1'b0;
            busy_ff <= 1'b0;
            cnt_ff  <= 4'h0;
        end else begin
            prev_ff <= req;
            if (req && !prev_ff) begin
                busy_ff <= 1'b1;
                cnt_ff  <= 4'h1;
            end else if (target_rdy_out) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule // target_sys_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench: register access over AHB-Lite, then timed bus requests.
// Assumes the target model answers every request on the shared target ready.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in    = 1'b0;
    logic        resetn_in = 1'b0;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic [1:0]  req = 2'h0, burst = 2'h0, resume = 2'h0, hit = 2'h0, bank = 2'h0;
    logic [1:0]  rdy;
    logic [1:0]  to_emul;
    logic        target_rdy;
    logic [3:0]  t_waits = 4'h0;
    logic [31:0] rd;
    int          err_total = 0;
    int          total_checks = 0;
    int          n0;
    int          n1;
    int          t;
    logic [6:0]  cfg_code [4] = '{7'h01, 7'h05, 7'h07, 7'h00};

    always #20 clk_in = ~clk_in;

    emul_wait_gen i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
        .hrdata_out(hrdata), .i_bus_request_strobe_in(req[0]), .i_burst_in(burst[0]),
        .i_resume_in(resume[0]), .i_emul_hit_in(hit[0]), .i_bank_in(bank[0]),
        .i_rdy_out(rdy[0]), .i_to_emul_out(to_emul[0]), .d_bus_request_strobe_in(req[1]),
        .d_burst_in(burst[1]), .d_resume_in(resume[1]), .d_emul_hit_in(hit[1]),
        .d_bank_in(bank[1]), .d_rdy_out(rdy[1]), .d_to_emul_out(to_emul[1]),
        .target_rdy_in(target_rdy));

    target_sys_model i_target (.clk_in(clk_in), .resetn_in(resetn_in), .i_req_in(req[0]),
        .d_req_in(req[1]), .waits_in(t_waits), .target_rdy_out(target_rdy));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_in);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        q = hrdata;
    endtask

    // Edges from take to ready sampled: waits plus one
    task automatic breq(input int b, input int k, input logic h, input logic bk, output int n);
        @(posedge clk_in);
        req[b]    <= 1'b1;
        burst[b]  <= (k == 1);
        resume[b] <= (k == 2);
        hit[b]    <= h;
        bank[b]   <= bk;
        @(posedge clk_in);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (rdy[b] !== 1'b1 && n < 300);
        req[b] <= 1'b0;
    endtask

    // Modes 0..2 normal one-clock, normal two-clock, fast; 3 memory off
    function automatic int exp_w(input int m, input int k, input int h, input int los,
                                 input int lk, input int tw, input int bm, input int sm);
        int tab [3][3] = '{'{2, 1, 2}, '{3, 2, 3}, '{4, 2, 3}};
        int w;
        if (m == 3) return tw;
        if (h == 0) begin
            w = (m == 2 && k == 0) ? 1 : 0;
            return (w > tw) ? w : tw;
        end
        w = tab[m][k] + los;
        if (k == 0 && sm > w) w = sm;
        if (k != 0 && bm > w) w = bm;
        if (lk != 0 && tw > w) w = tw;
        return w;
    endfunction

    task automatic coll(input logic [6:0] c, input logic bi, input logic bd,
                        input int ei, input int ed);
        ahb(1'b1, 32'h0, {25'h0, c}, rd);
        fork
            breq(0, 0, 1'b1, bi, n0);
            breq(1, 0, 1'b1, bd, n1);
        join
        check("collide I", n0, ei);
        check("collide D", n1, ed);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0, rd);
        check("config reset", rd, 32'h0);
        ahb(1'b0, 32'h4, 32'h0, rd);
        check("waits reset", rd, 32'h0000_0201);
        ahb(1'b0, 32'hC, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        check("okay resp", {31'h0, hresp}, 32'h0);
        ahb(1'b1, 32'h8, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 32'h8, 32'h0, rd);
        check("status busy", {30'h0, rd[1:0]}, 32'h0);
        ahb(1'b1, 32'h4, 32'h0000_0904, rd);
        ahb(1'b1, 32'h4, 32'h0000_0A00, rd);
        ahb(1'b0, 32'h4, 32'h0, rd);
        check("waits range", rd, 32'h0000_0904);
        ahb(1'b1, 32'h0, 32'h0000_0001, rd);
        breq(0, 0, 1'b1, 1'b0, n0);
        check("simple min 9", n0, exp_w(0, 0, 1, 0, 0, 0, 4, 9) + 1);
        breq(1, 1, 1'b1, 1'b0, n0);
        check("burst min 4", n0, exp_w(0, 1, 1, 0, 0, 0, 4, 9) + 1);
        ahb(1'b1, 32'h4, 32'h0000_0201, rd);
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, 32'h0, {25'h0, cfg_code[m]}, rd);
            for (int k = 0; k < 3; k++) begin
                for (int h = 0; h < 2; h++) begin
                    t = (m == 2 && k == 0) ? 1 : 0;
                    t_waits <= t[3:0];
                    breq(k % 2, k, h[0], 1'b0, n0);
                    check("bus waits", n0, exp_w(m, k, h, 0, 0, t, 1, 2) + 1);
                    check("to emul", to_emul[k % 2], (h == 1 && m != 3));
                end
            end
        end
        ahb(1'b1, 32'h0, 32'h0000_0009, rd);
        t_waits <= 4'h5;
        breq(0, 0, 1'b1, 1'b0, n0);
        check("lock I", n0, exp_w(0, 0, 1, 0, 1, 5, 1, 2) + 1);
        breq(1, 0, 1'b1, 1'b0, n0);
        check("unlocked D", n0, exp_w(0, 0, 1, 0, 0, 5, 1, 2) + 1);
        t_waits <= 4'h3;
        breq(0, 0, 1'b0, 1'b0, n0);
        check("target waits", n0, exp_w(0, 0, 0, 0, 0, 3, 1, 2) + 1);
        coll(7'h01, 1'b0, 1'b0, 3, 4);
        coll(7'h21, 1'b0, 1'b0, 4, 3);
        coll(7'h41, 1'b1, 1'b1, 4, 3);
        coll(7'h01, 1'b0, 1'b1, 3, 3);
        fork
            breq(0, 0, 1'b1, 1'b0, n0);
            begin
                @(posedge clk_in);
                breq(1, 1, 1'b1, 1'b0, n1);
            end
        join
        check("overlap I", n0, 3);
        check("overlap D", n1, 2);
        print_verdict();
    end

    initial begin
        #(40 * 20000);
        err_total++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
